// ==== hw/and_branch_defs.vh ====
/*
 * Constants shared by the AND-with-file / branch-on-carry execute slice:
 * opcode patterns, instruction field positions, addressing limits and
 * the one-hot quarter-phase codes of an instruction cycle.
 * Assumes it is included by its bare name from the files under hw/.
 */
`ifndef AND_BRANCH_DEFS_VH
`define AND_BRANCH_DEFS_VH

// ============================================================
// Instruction word layout
// ============================================================
`define INSTR_W 16
`define AWF_OPCODE 6'h05
`define AWF_OPC_MSB 15
`define AWF_OPC_LSB 10
`define AWF_DEST_BIT 9
`define AWF_ACC_BIT 8
`define FILE_MSB 7
`define FILE_LSB 0
`define BC_OPCODE 8'hE2
`define BC_OPC_MSB 15
`define BC_OPC_LSB 8
`define OFFS_MSB 7
`define OFFS_LSB 0

// ============================================================
// Field values
// ============================================================
`define DEST_TO_W 1'b0
`define ACC_BANK_SEL 1'b0
`define CARRY_SET 1'b1

// ============================================================
// Data-memory addressing
// ============================================================
`define FADDR_W 12
`define BSR_W 4
`define IDX_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h60
`define ACCESS_LO_BANK 4'h0
`define ACCESS_HI_BANK 4'hF

// ============================================================
// Program counter
// ============================================================
`define PC_W_DEF 21
`define PC_STEP 3'h2
`define PC_STEP_W 3

// ============================================================
// Quarter phases, one-hot
// ============================================================
`define PH_W 4
`define PH_Q1 4'h1
`define PH_Q2 4'h2
`define PH_Q3 4'h4
`define PH_Q4 4'h8

`endif

// ==== hw/file_addr_resolve.v ====
/*
 * Resolves the 8-bit file field of an instruction into a full data-memory
 * address: bank-select, access bank or indexed literal offset.
 * Assumes purely combinational use from the decode phase of the core.
 */
`timescale 1ns/1ps
`include "and_branch_defs.vh"

module file_addr_resolve (
    input wire acc_sel_i,
    input wire [7:0] file_i,
    input wire [`BSR_W-1:0] bank_select_register_i,
    input wire ext_en_i,
    input wire [`FADDR_W-1:0] index_base_i,
    output reg [`FADDR_W-1:0] addr_o,
    output reg indexed_o
);

    always @* begin
        // Indexed mode only steals the low access region
        indexed_o = ext_en_i && (acc_sel_i == `ACC_BANK_SEL) &&
            (file_i <= `IDX_LIMIT);
        if (indexed_o) begin
            addr_o = index_base_i + {4'h0, file_i};
        end else if (acc_sel_i == `ACC_BANK_SEL) begin
            if (file_i < `ACCESS_SPLIT) begin
                addr_o = {`ACCESS_LO_BANK, file_i};
            end else begin
                addr_o = {`ACCESS_HI_BANK, file_i};
            end
        end else begin
            addr_o = {bank_select_register_i, file_i};
        end
    end

endmodule

// ==== hw/and_carry_exec.v ====
/*
 * Execute slice of an 8-bit core for two instructions: AND of the working
 * register with a file register, and branch-on-carry. Each instruction
 * cycle is four core clocks, one per quarter phase Q1..Q4. The next word
 * is prefetched while the current one executes and kept at the end of every cycle but a taken branch.
 * Assumes program memory and data memory sit on the same clock and answer
 * combinationally; carry, bank select, extended-set enable and index base
 * come from core logic on the same clock. Other opcodes execute as no-ops.
 */
// Notes on behaviour
// - AND-with-file: top six bits 000101, then dest bit, access bit, file
// - Result is working register ANDed with the addressed file register
// - Dest bit 0 writes the working register, 1 writes the file back
// - Access bit 0 uses the access bank, 1 uses bank select register
// - Extended set, access bit 0 and file at most 95 select indexed mode
// - AND-with-file finishes in one instruction cycle with no stall
// - Phases: decode Q1, read file Q2, process Q3, write dest Q4
// - Branch-on-carry taken only when carry is 1, else fall through
// - Taken target is branch address plus 2 plus twice signed offset
// - Taken branch costs two instruction cycles, not taken costs one
`timescale 1ns/1ps
`include "and_branch_defs.vh"

module and_carry_exec #(
    parameter PC_W = `PC_W_DEF
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire [`INSTR_W-1:0] instr_i,
    input wire carry_i,
    input wire [`BSR_W-1:0] bank_select_register_i,
    input wire ext_en_i,
    input wire [`FADDR_W-1:0] index_base_i,
    input wire [7:0] file_rdata_i,
    output reg [PC_W-1:0] prog_addr_o,
    output reg [`PH_W-1:0] phase_o,
    output reg [`FADDR_W-1:0] file_addr_o,
    output reg file_rd_o,
    output reg file_wr_o,
    output reg [7:0] file_wdata_o,
    output reg [7:0] working_o,
    output reg neg_flag_o,
    output reg zero_flag_o,
    output reg branch_taken_o
);

    localparam [`PH_W-1:0] PH_Q1 = `PH_Q1;
    localparam [`PH_W-1:0] PH_Q2 = `PH_Q2;
    localparam [`PH_W-1:0] PH_Q3 = `PH_Q3;
    localparam [`PH_W-1:0] PH_Q4 = `PH_Q4;
    localparam [PC_W-1:0] PC_STEP =
        {{(PC_W-`PC_STEP_W){1'b0}}, `PC_STEP};

    // ============================================================
    // Instruction register and its fields
    // ============================================================
    reg [`INSTR_W-1:0] ir;
    reg ir_valid;
    reg [PC_W-1:0] ir_addr;

    wire [5:0] awf_opc = ir[`AWF_OPC_MSB:`AWF_OPC_LSB];
    wire [7:0] bc_opc = ir[`BC_OPC_MSB:`BC_OPC_LSB];
    wire ir_dest = ir[`AWF_DEST_BIT];
    wire ir_acc = ir[`AWF_ACC_BIT];
    wire [7:0] ir_file = ir[`FILE_MSB:`FILE_LSB];
    wire [7:0] ir_offs = ir[`OFFS_MSB:`OFFS_LSB];

    wire is_awf = ir_valid && (awf_opc == `AWF_OPCODE);
    wire is_bc = ir_valid && (bc_opc == `BC_OPCODE);

    // ============================================================
    // Operand address
    // ============================================================
    wire [`FADDR_W-1:0] res_addr;

    file_addr_resolve u_resolve (
        .acc_sel_i(ir_acc),
        .file_i(ir_file),
        .bank_select_register_i(bank_select_register_i),
        .ext_en_i(ext_en_i),
        .index_base_i(index_base_i),
        .addr_o(res_addr),
        .indexed_o()
    );

    // ============================================================
    // Decoded state held across the cycle
    // ============================================================
    reg dec_and;
    reg dec_bc;
    reg dec_dest;
    reg [7:0] dec_offs;
    reg [7:0] operand;
    reg [7:0] result;
    reg take;
    reg [PC_W-1:0] target;

    // Offset doubled and sign-extended to the counter width
    wire [PC_W-1:0] offs_x2 =
        {{(PC_W-9){dec_offs[7]}}, dec_offs, 1'b0};
    wire [PC_W-1:0] next_target = ir_addr + PC_STEP + offs_x2;
    wire [7:0] next_result = working_o & operand;

    // ============================================================
    // Quarter-phase sequencer
    // ============================================================
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            phase_o <= PH_Q1;
        end else begin
            case (phase_o)
                PH_Q1: phase_o <= PH_Q2;
                PH_Q2: phase_o <= PH_Q3;
                PH_Q3: phase_o <= PH_Q4;
                PH_Q4: phase_o <= PH_Q1;
                default: phase_o <= PH_Q1;
            endcase
        end
    end

    // ============================================================
    // Q1: decode
    // ============================================================
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            dec_and <= 1'b0;
            dec_bc <= 1'b0;
            dec_dest <= 1'b0;
            dec_offs <= 8'h00;
        end else if (phase_o == PH_Q1) begin
            dec_and <= is_awf;
            dec_bc <= is_bc;
            dec_dest <= ir_dest;
            dec_offs <= ir_offs;
        end
    end

    // ============================================================
    // Data-memory strobes: read held through Q2, write through Q4
    // ============================================================
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            file_addr_o <= {`FADDR_W{1'b0}};
            file_rd_o <= 1'b0;
            file_wr_o <= 1'b0;
            file_wdata_o <= 8'h00;
        end else begin
            case (phase_o)
                PH_Q1: begin
                    // Address stays put until the next decode so the
                    // write in Q4 lands on the register that was read
                    if (is_awf) begin
                        file_addr_o <= res_addr;
                    end
                    file_rd_o <= is_awf;
                    file_wr_o <= 1'b0;
                end
                PH_Q2: begin
                    file_rd_o <= 1'b0;
                    file_wr_o <= 1'b0;
                end
                PH_Q3: begin
                    file_rd_o <= 1'b0;
                    file_wr_o <= dec_and && (dec_dest != `DEST_TO_W);
                    file_wdata_o <= next_result;
                end
                PH_Q4: begin
                    file_rd_o <= 1'b0;
                    file_wr_o <= 1'b0;
                end
                default: begin
                    file_rd_o <= 1'b0;
                    file_wr_o <= 1'b0;
                end
            endcase
        end
    end

    // ============================================================
    // Q2 read, Q3 process
    // ============================================================
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            operand <= 8'h00;
            result <= 8'h00;
            take <= 1'b0;
            target <= {PC_W{1'b0}};
        end else begin
            if (phase_o == PH_Q2 && dec_and) begin
                operand <= file_rdata_i;
            end
            if (phase_o == PH_Q3) begin
                result <= next_result;
                take <= dec_bc && (carry_i == `CARRY_SET);
                target <= next_target;
            end
        end
    end

    // ============================================================
    // Q4: write destination and flags
    // ============================================================
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            working_o <= 8'h00;
            neg_flag_o <= 1'b0;
            zero_flag_o <= 1'b0;
        end else if (phase_o == PH_Q4 && dec_and) begin
            // Whole AND completes here; no stall cycle follows
            if (dec_dest == `DEST_TO_W) begin
                working_o <= result;
            end
            neg_flag_o <= result[7];
            zero_flag_o <= (result == 8'h00);
        end
    end

    // ============================================================
    // Q4: fetch, branch and flush
    // ============================================================
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prog_addr_o <= {PC_W{1'b0}};
            ir <= {`INSTR_W{1'b0}};
            ir_valid <= 1'b0;
            ir_addr <= {PC_W{1'b0}};
            branch_taken_o <= 1'b0;
        end else if (phase_o == PH_Q4) begin
            if (take) begin
                // Prefetched word is discarded: the next cycle runs as a
                // no-op while the word at the target is fetched
                prog_addr_o <= target;
                ir_valid <= 1'b0;
                branch_taken_o <= 1'b1;
            end else begin
                ir <= instr_i;
                ir_valid <= 1'b1;
                ir_addr <= prog_addr_o;
                prog_addr_o <= prog_addr_o + PC_STEP;
                branch_taken_o <= 1'b0;
            end
        end else begin
            branch_taken_o <= 1'b0;
        end
    end

endmodule

// ==== verification/prog_mem_model.sv ====
/* Program memory seen by the execute slice: one 16-bit word per two addresses.
   Assumes byte addressing, so bit 0 of the address is ignored. */
`timescale 1ns/1ps
// =====
// Word store
// =====
module prog_mem #(parameter PC_W = 21) (
    input wire [PC_W-1:0] addr_i,
    output wire [15:0] word_o
);
    logic [15:0] mem [0:63];
    // Past the image the word changes with the address, never a stale value
    assign word_o = (addr_i < 128) ? mem[addr_i[6:1]] : ~addr_i[15:0];
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
    end
endmodule

// ==== verification/and_carry_exec_monitor.sv ====
/* Port checker for and_carry_exec.
   Assumes it is bound to the top module on its single clock. */
`timescale 1ns/1ps
`include "and_branch_defs.vh"
module and_carry_exec_monitor #(parameter PC_W = 21) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire [15:0] instr_i,
    input wire carry_i,
    input wire [3:0] bank_select_register_i,
    input wire ext_en_i,
    input wire [11:0] index_base_i,
    input wire [7:0] file_rdata_i,
    input wire [PC_W-1:0] prog_addr_o,
    input wire [3:0] phase_o,
    input wire [11:0] file_addr_o,
    input wire file_rd_o,
    input wire file_wr_o,
    input wire [7:0] file_wdata_o,
    input wire [7:0] working_o,
    input wire neg_flag_o,
    input wire zero_flag_o,
    input wire branch_taken_o
);
    // =====
    // Helpers
    // =====
    reg [15:0] cur_ir;
    reg [7:0] rd_q;
    reg dead;
    // A flushed cycle must behave as a no-op whatever word it holds
    wire kill = branch_taken_o | dead;
    wire is_and = (cur_ir[15:10] == `AWF_OPCODE) && !kill;
    wire is_bc = (cur_ir[15:8] == `BC_OPCODE) && !kill;
    wire [7:0] res = working_o & rd_q;
    wire [PC_W-1:0] disp = {{(PC_W-9){cur_ir[7]}}, cur_ir[7:0], 1'b0};
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cur_ir <= 16'h0000;
            rd_q <= 8'h00;
            dead <= 1'b0;
        end else begin
            if (phase_o == `PH_Q4) cur_ir <= instr_i;
            if (file_rd_o) rd_q <= file_rdata_i;
            dead <= (phase_o == `PH_Q4) ? 1'b0 : kill;
        end
    end
    function automatic [11:0] exp_addr(input [15:0] ir, input [3:0] bank,
                                       input ext, input [11:0] base);
        if (ir[8]) exp_addr = {bank, ir[7:0]};
        else if (ext && ir[7:0] <= 8'h5F) exp_addr = base + ir[7:0];
        else if (ir[7:0] < 8'h60) exp_addr = {4'h0, ir[7:0]};
        else exp_addr = {4'hF, ir[7:0]};
    endfunction
    // =====
    // Assertions
    // =====
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence phase_walk;
        phase_o == `PH_Q2 ##1 phase_o == `PH_Q3 ##1 phase_o == `PH_Q4
            ##1 phase_o == `PH_Q1;
    endsequence
    sequence and_walk;
        file_rd_o ##1 (!file_rd_o && !file_wr_o) ##1 file_wr_o == cur_ir[9];
    endsequence
    phase_order_a: assert property (phase_o == `PH_Q1 |=> phase_walk)
        else $error("quarter phases out of order");
    and_steps_a: assert property (phase_o == `PH_Q1 && is_and |=> and_walk)
        else $error("file read or write misplaced");
    addr_pick_a: assert property (phase_o == `PH_Q1 && is_and |=>
        file_addr_o == exp_addr(cur_ir, $past(bank_select_register_i),
                                $past(ext_en_i), $past(index_base_i)))
        else $error("wrong file address");
    wdata_and_a: assert property (file_wr_o |-> file_wdata_o == res)
        else $error("write data is not the AND result");
    flag_update_a: assert property (phase_o == `PH_Q4 && is_and |=>
        neg_flag_o == $past(res[7]) && zero_flag_o == ($past(res) == 8'h00)
        && working_o == ($past(cur_ir[9]) ? $past(working_o) : $past(res)))
        else $error("flags or working register wrong");
    stray_strobe_a: assert property ((file_rd_o || file_wr_o) |-> is_and)
        else $error("strobe outside a live AND");
    seq_step_a: assert property (phase_o == `PH_Q4 && !is_bc |=>
        prog_addr_o == $past(prog_addr_o) + 2)
        else $error("sequential fetch step wrong");
    bc_taken_a: assert property (phase_o == `PH_Q3 && is_bc && carry_i |=>
        ##1 branch_taken_o && prog_addr_o == $past(prog_addr_o, 2) + $past(disp, 2))
        else $error("taken branch target wrong");
    bc_fall_a: assert property (phase_o == `PH_Q3 && is_bc && !carry_i |=>
        ##1 !branch_taken_o && prog_addr_o == $past(prog_addr_o, 2) + 2)
        else $error("untaken branch did not fall through");
    taken_pulse_a: assert property (branch_taken_o |->
        phase_o == `PH_Q1 ##1 !branch_taken_o [*3])
        else $error("flush marker not a Q1 pulse");
endmodule

// ==== verification/tb_top.sv ====
/* Self-checking bench for and_carry_exec with scenario tasks.
   Assumes prog_mem and the monitor are compiled before it. */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    miscompares++; $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module tb_top;
    // =====
    // Harness
    // =====
    localparam PC_W = 21;
    logic mclk_i = 0, sys_rst_i = 1, carry_i = 0, ext_en_i = 0;
    logic [3:0] bank_select_register_i = 4'h3;
    logic [11:0] index_base_i = 12'h123;
    wire [15:0] instr_i;
    wire [7:0] file_rdata_i, file_wdata_o, working_o;
    wire [PC_W-1:0] prog_addr_o;
    wire [3:0] phase_o;
    wire [11:0] file_addr_o;
    wire file_rd_o, file_wr_o, neg_flag_o, zero_flag_o, branch_taken_o;
    int miscompares = 0, check_count = 0, rd_cnt, wr_cnt, tk_cnt;
    logic [11:0] rd_addr;
    // Read data is a fixed function of the address, so it is predictable
    assign file_rdata_i = file_addr_o[7:0] ^ 8'h3C;
    always #2 mclk_i = ~mclk_i;
    prog_mem #(.PC_W(PC_W)) u_mem (.addr_i(prog_addr_o), .word_o(instr_i));
    and_carry_exec #(.PC_W(PC_W)) u_dut (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .instr_i(instr_i), .carry_i(carry_i),
        .bank_select_register_i(bank_select_register_i),
        .ext_en_i(ext_en_i), .index_base_i(index_base_i),
        .file_rdata_i(file_rdata_i), .prog_addr_o(prog_addr_o),
        .phase_o(phase_o), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
        .file_wr_o(file_wr_o), .file_wdata_o(file_wdata_o),
        .working_o(working_o), .neg_flag_o(neg_flag_o),
        .zero_flag_o(zero_flag_o), .branch_taken_o(branch_taken_o));
    always @(posedge mclk_i) begin
        if (file_rd_o) begin
            rd_cnt++;
            rd_addr = file_addr_o;
        end
        if (file_wr_o) wr_cnt++;
        if (branch_taken_o) tk_cnt++;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic restart(input logic [15:0] w0, input logic [15:0] w1);
        sys_rst_i = 1;
        tick(20);
        // Image loaded after the memory's own fill so time zero cannot race
        u_mem.mem[0] = w0;
        u_mem.mem[1] = w1;
        sys_rst_i = 0;
        rd_cnt = 0;
        wr_cnt = 0;
        tk_cnt = 0;
    endtask
    // =====
    // Scenarios
    // =====
    task automatic sc_and_modes();
        logic [15:0] w [5] = '{16'h1780, 16'h1420, 16'h1670, 16'h165F,
                               16'h1660};
        logic [11:0] ea [5] = '{12'h380, 12'h020, 12'hF70, 12'h182, 12'hF60};
        logic ext [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 5; i++) begin
            ext_en_i = ext[i];
            restart(w[i], 16'hFFFF);
            tick(12);
            `CHK(rd_cnt, 1);
            `CHK(rd_addr, ea[i]);
            `CHK(wr_cnt, int'(w[i][9]));
            `CHK(zero_flag_o, 1'b1);
            `CHK(working_o, 8'h00);
            `CHK(file_wdata_o, 8'h00);
            `CHK(neg_flag_o, 1'b0);
            `CHK(phase_o, 4'h1);
        end
    endtask
    task automatic sc_branch();
        logic [7:0] n [4] = '{8'h05, 8'h05, 8'h80, 8'h7F};
        logic cy [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        logic [PC_W-1:0] pc [4] = '{21'h00000C, 21'h000004, 21'h1FFF02,
                                    21'h000100};
        for (int i = 0; i < 4; i++) begin
            carry_i = cy[i];
            restart({8'hE2, n[i]}, 16'h1780);
            tick(8);
            `CHK(prog_addr_o, pc[i]);
            `CHK(branch_taken_o, cy[i]);
            tick(8);
            `CHK(rd_cnt, int'(!cy[i]));
            `CHK(tk_cnt, int'(cy[i]));
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end
    initial begin
        sc_and_modes();
        sc_branch();
        finish_test();
    end
endmodule
bind and_carry_exec and_carry_exec_monitor #(.PC_W(PC_W)) u_mon (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
    .carry_i(carry_i), .bank_select_register_i(bank_select_register_i),
    .ext_en_i(ext_en_i), .index_base_i(index_base_i),
    .file_rdata_i(file_rdata_i), .prog_addr_o(prog_addr_o),
    .phase_o(phase_o), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
    .file_wr_o(file_wr_o), .file_wdata_o(file_wdata_o),
    .working_o(working_o), .neg_flag_o(neg_flag_o),
    .zero_flag_o(zero_flag_o), .branch_taken_o(branch_taken_o));
